// >>> src/dcc_cmd_top.sv
// Sensor card configuration command decoder, top level
// Behaviour
// - Command 0x0102 replies with the converter control setting, payload ignored.
// - Command 0x0103 reloads all gain converter registers with defaults.
// - Converter write takes data 15:0, address 25:18, chip select 27.
// - Chip select 0 targets channels 0-7, 1 targets 8-15.
// - Bit 31 of converter write targets all chips, ignoring chip select.
// - Gains live at 0x2A and 0x2B of each chip, nibble order mirrored.
// - Command 0x0105 restores all threshold converters to defaults.
// - Threshold write: data 9:0, channel 16:13, command 20:17, chip 26:23.
// - Type 28:27 decodes energy, timing, reserved, all.
// - Bit 31 of threshold write targets every chip of the type.
// - Channel 0-3 selects output n alone, channels 4-14 select none; 0xF means all four.
// - Sawtooth: chip 3:0, type 5:4, count 13:6, then that many pulses.
// - Bit 31 of sawtooth drives all chips of the type.
// - Threshold command stores value 11:0 and mode 17:16, 01 enables.
// - Threshold is offset binary; MSB alone is the zero-volt level.
// - Command 0x0109 returns stored value and mode in written positions.
// - Control setting is bits 7:0; 0x80 reset, 0x02 calibrate, 0x04 run.
`timescale 1ns/1ps
`default_nettype none
module dcc_cmd_top #(
	parameter int SAW_PERIOD = dcc_pkg::SAW_PERIOD_CYC
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic cmd_valid_in,
	output logic cmd_ready_out,
	input wire logic [dcc_pkg::ID_W-1:0] command_identifier_in,
	input wire logic [dcc_pkg::PAY_W-1:0] cmd_payload_in,
	output logic rsp_valid_out,
	input wire logic rsp_ready_in,
	output logic [dcc_pkg::ID_W-1:0] rsp_id_out,
	output logic [dcc_pkg::PAY_W-1:0] rsp_payload_out,
	output logic adc_valid_out,
	input wire logic adc_ready_in,
	output logic adc_default_out,
	output logic [1:0] adc_chip_mask_out,
	output logic [dcc_pkg::ADC_ADDR_W-1:0] adc_addr_out,
	output logic [dcc_pkg::ADC_DATA_W-1:0] adc_data_out,
	output logic adc_gain_out,
	output logic dac_valid_out,
	input wire logic dac_ready_in,
	output logic dac_default_out,
	output logic [dcc_pkg::DAC_DATA_W-1:0] dac_data_out,
	output logic [3:0] dac_chan_mask_out,
	output logic [3:0] dac_cmd_out,
	output logic [3:0] dac_chip_out,
	output logic dac_all_chips_out,
	output logic [1:0] dac_type_mask_out,
	output logic saw_pulse_out,
	output logic saw_busy_out,
	output logic [3:0] saw_chip_out,
	output logic saw_all_chips_out,
	output logic [1:0] saw_type_mask_out,
	output logic [dcc_pkg::TDC_W-1:0] tdc_ctrl_out,
	output logic tdc_reset_out,
	output logic tdc_cal_out,
	output logic tdc_run_out,
	output logic [dcc_pkg::THR_W-1:0] thr_value_out,
	output logic [1:0] thr_mode_out,
	output logic thr_enable_out
);
	import dcc_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		dcc_state_e st;
		logic [15:0] id;
		logic async;
		logic [31:0] pay;
		logic rsp_valid;
		logic [31:0] rsp_pay;
		logic adc_valid;
		logic adc_def;
		logic [1:0] adc_cs;
		logic [7:0] adc_addr;
		logic [15:0] adc_data;
		logic adc_gain;
		logic dac_valid;
		logic dac_def;
		logic [9:0] dac_data;
		logic [3:0] dac_chmask;
		logic [3:0] dac_cmd;
		logic [3:0] dac_chip;
		logic dac_all;
		logic [1:0] dac_types;
		logic saw_go;
		logic [7:0] saw_cnt;
		logic [3:0] saw_chip;
		logic saw_all;
		logic [1:0] saw_types;
		logic [7:0] tdc;
		logic tdc_rst;
		logic tdc_cal;
		logic tdc_run;
		logic [11:0] thr;
		logic [1:0] thr_mode;
	} dcc_main_s;

	// Threshold wakes at mid scale, i.e. zero volts
	localparam dcc_main_s MAIN_RST = '{st: ST_IDLE, tdc: TDC_RST, thr: THR_RST, default: '0};

	dcc_main_s s_ff;
	dcc_main_s nxt_s;
	logic [14:0] op;
	logic [7:0] wr_addr;
	dcc_link_if lk();

	assign op = s_ff.id[14:0];
	assign wr_addr = s_ff.pay[ADC_ADDR_LSB +: ADC_ADDR_W];
	assign lk.dec_payload = s_ff.pay;
	assign lk.saw_start = s_ff.saw_go;
	assign lk.saw_count = s_ff.saw_cnt;

	dcc_dac_dec u_dec (
		.lk(lk)
	);

	dcc_saw_gen #(
		.PERIOD_CYC(SAW_PERIOD)
	) u_saw (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.lk(lk)
	);

	// ----------------------------------------
	// Command sequencing
	// ----------------------------------------
	always_comb
	begin
		nxt_s = s_ff;
		nxt_s.saw_go = 1'b0;
		unique case (s_ff.st)
		ST_IDLE:
		begin
			if (cmd_valid_in)
			begin
				nxt_s.id = {1'b1, command_identifier_in[14:0]};
				nxt_s.async = command_identifier_in[ID_ASYNC_BIT];
				nxt_s.pay = cmd_payload_in;
				nxt_s.st = ST_EXEC;
			end
		end
		ST_EXEC:
		begin
			nxt_s.st = ST_REPLY;
			nxt_s.rsp_valid = 1'b1;
			nxt_s.rsp_pay = '0;
			case (op)
			CMD_TDC_SET:
			begin
				nxt_s.tdc = s_ff.pay[TDC_W-1:0];
				nxt_s.tdc_rst = s_ff.pay[TDC_W-1:0] == TDC_CODE_RESET;
				nxt_s.tdc_cal = s_ff.pay[TDC_W-1:0] == TDC_CODE_CAL;
				nxt_s.tdc_run = s_ff.pay[TDC_W-1:0] == TDC_CODE_RUN;
			end
			CMD_TDC_GET:
				nxt_s.rsp_pay = {{(PAY_W-TDC_W){1'b0}}, s_ff.tdc};
			CMD_ADC_RST, CMD_ADC_WR:
			begin
				nxt_s.st = ST_HOLD;
				nxt_s.rsp_valid = 1'b0;
				nxt_s.adc_valid = 1'b1;
				nxt_s.adc_def = op == CMD_ADC_RST;
				nxt_s.adc_data = s_ff.pay[ADC_DATA_W-1:0];
				nxt_s.adc_addr = wr_addr;
				nxt_s.adc_gain = wr_addr == ADC_GAIN_LO || wr_addr == ADC_GAIN_HI;
				if (op == CMD_ADC_RST || s_ff.pay[BCAST_BIT])
					nxt_s.adc_cs = 2'h3;
				else
					nxt_s.adc_cs = s_ff.pay[ADC_CS_BIT] ? 2'h2 : 2'h1;
			end
			CMD_DAC_RST, CMD_DAC_WR:
			begin
				nxt_s.st = ST_HOLD;
				nxt_s.rsp_valid = 1'b0;
				nxt_s.dac_valid = 1'b1;
				nxt_s.dac_def = op == CMD_DAC_RST;
				nxt_s.dac_data = lk.dec_data;
				nxt_s.dac_chmask = lk.dec_chmask;
				nxt_s.dac_cmd = lk.dec_cmd;
				nxt_s.dac_chip = lk.dec_chip;
				nxt_s.dac_types = (op == CMD_DAC_RST) ? 2'h3 : lk.dec_types;
				nxt_s.dac_all = (op == CMD_DAC_RST) || lk.dec_all;
			end
			CMD_SAW:
			begin
				if (lk.saw_busy)
				begin
					// A train is still running: hold this one back
					nxt_s.st = ST_EXEC;
					nxt_s.rsp_valid = 1'b0;
				end
				else
				begin
					nxt_s.saw_go = 1'b1;
					nxt_s.saw_cnt = s_ff.pay[SAW_CNT_LSB +: SAW_CNT_W];
					nxt_s.saw_chip = s_ff.pay[SAW_CHIP_LSB +: 4];
					nxt_s.saw_types = dcc_type_mask(s_ff.pay[SAW_TYPE_LSB +: 2]);
					nxt_s.saw_all = s_ff.pay[BCAST_BIT];
					// Non-blocking form replies at once
					if (!s_ff.async && s_ff.pay[SAW_CNT_LSB +: SAW_CNT_W] != 8'h00)
					begin
						nxt_s.st = ST_SAW;
						nxt_s.rsp_valid = 1'b0;
					end
				end
			end
			CMD_THR_SET:
			begin
				nxt_s.thr = s_ff.pay[THR_W-1:0];
				nxt_s.thr_mode = s_ff.pay[THR_MODE_LSB +: 2];
			end
			CMD_THR_GET:
				nxt_s.rsp_pay = {14'h0000, s_ff.thr_mode, 4'h0, s_ff.thr};
			default:
				nxt_s.rsp_pay = '0;
			endcase
		end
		ST_HOLD:
		begin
			if ((s_ff.adc_valid && adc_ready_in) || (s_ff.dac_valid && dac_ready_in))
			begin
				nxt_s.adc_valid = 1'b0;
				nxt_s.dac_valid = 1'b0;
				nxt_s.st = ST_REPLY;
				nxt_s.rsp_valid = 1'b1;
			end
		end
		ST_SAW:
		begin
			if (!lk.saw_busy)
			begin
				nxt_s.st = ST_REPLY;
				nxt_s.rsp_valid = 1'b1;
			end
		end
		ST_REPLY:
		begin
			if (rsp_ready_in)
			begin
				nxt_s.rsp_valid = 1'b0;
				nxt_s.st = ST_IDLE;
			end
		end
		default:
			nxt_s = MAIN_RST;
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			s_ff <= MAIN_RST;
		else
			s_ff <= nxt_s;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign cmd_ready_out = s_ff.st == ST_IDLE;
	assign rsp_valid_out = s_ff.rsp_valid;
	assign rsp_id_out = s_ff.id;
	assign rsp_payload_out = s_ff.rsp_pay;
	assign adc_valid_out = s_ff.adc_valid;
	assign adc_default_out = s_ff.adc_def;
	assign adc_chip_mask_out = s_ff.adc_cs;
	assign adc_addr_out = s_ff.adc_addr;
	assign adc_data_out = s_ff.adc_data;
	assign adc_gain_out = s_ff.adc_gain;
	assign dac_valid_out = s_ff.dac_valid;
	assign dac_default_out = s_ff.dac_def;
	assign dac_data_out = s_ff.dac_data;
	assign dac_chan_mask_out = s_ff.dac_chmask;
	assign dac_cmd_out = s_ff.dac_cmd;
	assign dac_chip_out = s_ff.dac_chip;
	assign dac_all_chips_out = s_ff.dac_all;
	assign dac_type_mask_out = s_ff.dac_types;
	assign saw_pulse_out = lk.saw_tick;
	assign saw_busy_out = lk.saw_busy;
	assign saw_chip_out = s_ff.saw_chip;
	assign saw_all_chips_out = s_ff.saw_all;
	assign saw_type_mask_out = s_ff.saw_types;
	assign tdc_ctrl_out = s_ff.tdc;
	assign tdc_reset_out = s_ff.tdc_rst;
	assign tdc_cal_out = s_ff.tdc_cal;
	assign tdc_run_out = s_ff.tdc_run;
	assign thr_value_out = s_ff.thr;
	assign thr_mode_out = s_ff.thr_mode;
	assign thr_enable_out = s_ff.thr_mode == THR_MODE_ON;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	logic acc;
	logic [31:0] p;
	logic [7:0] pulses;
	assign acc = cmd_valid_in && cmd_ready_out;
	assign p = cmd_payload_in;
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			pulses <= 8'h00;
		else if (s_ff.saw_go)
			pulses <= 8'h00;
		else if (saw_pulse_out)
			pulses <= pulses + 8'h01;
	end

	a_reply_id_bit: assert property (acc |=> rsp_id_out == {1'b1, $past(command_identifier_in[14:0])})
		else $error("reply identifier lacks bit 15");
	a_tdc_read_back: assert property (acc && command_identifier_in[14:0] == CMD_TDC_GET
		|-> ##2 rsp_valid_out && rsp_payload_out == {24'h000000, tdc_ctrl_out})
		else $error("converter control read back wrong");
	a_adc_reload_all: assert property (acc && command_identifier_in[14:0] == CMD_ADC_RST
		|-> ##2 adc_valid_out && adc_default_out && adc_chip_mask_out == 2'h3)
		else $error("gain converter reload not issued");
	a_adc_write_fields: assert property (acc && command_identifier_in[14:0] == CMD_ADC_WR
		|-> ##2 adc_addr_out == $past(p[25:18], 2) && adc_data_out == $past(p[15:0], 2))
		else $error("gain converter write fields wrong");
	a_adc_chip_sel: assert property (acc && command_identifier_in[14:0] == CMD_ADC_WR && !p[31]
		|-> ##2 adc_chip_mask_out == ($past(p[27], 2) ? 2'h2 : 2'h1))
		else $error("gain converter chip select wrong");
	a_adc_bcast_all: assert property (acc && command_identifier_in[14:0] == CMD_ADC_WR && p[31]
		|-> ##2 adc_chip_mask_out == 2'h3)
		else $error("gain converter broadcast missed a chip");
	a_dac_reload_all: assert property (acc && command_identifier_in[14:0] == CMD_DAC_RST
		|-> ##2 dac_valid_out && dac_default_out && dac_all_chips_out)
		else $error("threshold converter reload not issued");
	a_dac_write_fields: assert property (acc && command_identifier_in[14:0] == CMD_DAC_WR
		|-> ##2 dac_data_out == $past(p[9:0], 2) && dac_chip_out == $past(p[26:23], 2)
		&& dac_cmd_out == $past(p[20:17], 2))
		else $error("threshold converter write fields wrong");
	a_dac_type_all: assert property (acc && command_identifier_in[14:0] == CMD_DAC_WR && p[28:27] == 2'h3
		|-> ##2 dac_type_mask_out == 2'h3 && dac_all_chips_out == $past(p[31], 2))
		else $error("threshold converter type decode wrong");
	a_dac_group_chan: assert property (acc && command_identifier_in[14:0] == CMD_DAC_WR && p[16:13] == 4'hF
		|-> ##2 dac_chan_mask_out == 4'hF)
		else $error("group channel address not all outputs");
	a_saw_pulse_count: assert property ($fell(saw_busy_out) |-> pulses == $past(s_ff.saw_cnt))
		else $error("sawtooth pulse count wrong");
	a_thr_store_read: assert property (acc && command_identifier_in[14:0] == CMD_THR_SET |-> ##2
		thr_value_out == $past(p[11:0], 2) && thr_mode_out == $past(p[17:16], 2))
		else $error("threshold store wrong");
	a_thr_read_back: assert property (acc && command_identifier_in[14:0] == CMD_THR_GET |-> ##2
		rsp_payload_out == {14'h0000, thr_mode_out, 4'h0, thr_value_out})
		else $error("threshold read back wrong");
	a_hold_valid: assert property (adc_valid_out && !adc_ready_in |=> adc_valid_out)
		else $error("converter request dropped before taken");

	c_saw_blocking: cover property (acc && command_identifier_in == 16'h0107 ##[1:50] $fell(saw_busy_out));
	c_adc_write: cover property (adc_valid_out && adc_ready_in && adc_gain_out);
	c_thr_read: cover property (rsp_valid_out && rsp_id_out == 16'h8109);
endmodule
`default_nettype wire

// >>> src/dcc_pkg.sv
// Shared constants, types and helpers of the sensor card command decoder
`default_nettype none
package dcc_pkg;
	// ----------------------------------------
	// Command identifiers and reply marking
	// ----------------------------------------
	localparam int ID_W = 16;
	localparam int PAY_W = 32;
	localparam int ID_ASYNC_BIT = 15;
	localparam logic [14:0] CMD_TDC_SET = 15'h0101;
	localparam logic [14:0] CMD_TDC_GET = 15'h0102;
	localparam logic [14:0] CMD_ADC_RST = 15'h0103;
	localparam logic [14:0] CMD_ADC_WR = 15'h0104;
	localparam logic [14:0] CMD_DAC_RST = 15'h0105;
	localparam logic [14:0] CMD_DAC_WR = 15'h0106;
	localparam logic [14:0] CMD_SAW = 15'h0107;
	localparam logic [14:0] CMD_THR_SET = 15'h0108;
	localparam logic [14:0] CMD_THR_GET = 15'h0109;
	// ----------------------------------------
	// Payload field positions
	// ----------------------------------------
	localparam int BCAST_BIT = 31;
	localparam int TDC_W = 8;
	localparam int ADC_DATA_W = 16;
	localparam int ADC_ADDR_LSB = 18;
	localparam int ADC_ADDR_W = 8;
	localparam int ADC_CS_BIT = 27;
	localparam int DAC_DATA_W = 10;
	localparam int DAC_CH_LSB = 13;
	localparam int DAC_CMD_LSB = 17;
	localparam int DAC_CHIP_LSB = 23;
	localparam int DAC_TYPE_LSB = 27;
	localparam int SAW_CHIP_LSB = 0;
	localparam int SAW_TYPE_LSB = 4;
	localparam int SAW_CNT_LSB = 6;
	localparam int SAW_CNT_W = 8;
	localparam int THR_W = 12;
	localparam int THR_MODE_LSB = 16;
	// ----------------------------------------
	// Codes and values after reset
	// ----------------------------------------
	localparam logic [7:0] TDC_CODE_RESET = 8'h80;
	localparam logic [7:0] TDC_CODE_CAL = 8'h02;
	localparam logic [7:0] TDC_CODE_RUN = 8'h04;
	localparam logic [7:0] TDC_RST = 8'h00;
	localparam logic [7:0] ADC_GAIN_LO = 8'h2A;
	localparam logic [7:0] ADC_GAIN_HI = 8'h2B;
	localparam logic [3:0] DAC_ALL_CH = 4'hF;
	localparam logic [3:0] DAC_SET_CMD = 4'h3;
	localparam logic [11:0] THR_RST = 12'h800;
	localparam logic [1:0] THR_MODE_ON = 2'h1;
	localparam int CLK_PERIOD_NS = 5;
	localparam int SAW_PERIOD_NS = 1000;
	localparam int SAW_PERIOD_CYC = SAW_PERIOD_NS / CLK_PERIOD_NS;
	typedef enum logic [2:0] {ST_IDLE, ST_EXEC, ST_HOLD, ST_SAW, ST_REPLY} dcc_state_e;
	// Type field to mask: bit 0 energy, bit 1 timing
	function automatic logic [1:0] dcc_type_mask(input logic [1:0] t);
		return (t == 2'h0) ? 2'h1 : (t == 2'h1) ? 2'h2 : (t == 2'h3) ? 2'h3 : 2'h0;
	endfunction
endpackage
`default_nettype wire

// >>> src/dcc_link_if.sv
// Links between the decoder core, the pulse generator and the field decoder
`timescale 1ns/1ps
`default_nettype none
interface dcc_link_if;
	logic saw_start;
	logic [7:0] saw_count;
	logic saw_busy;
	logic saw_tick;
	logic [31:0] dec_payload;
	logic [9:0] dec_data;
	logic [3:0] dec_chmask;
	logic [3:0] dec_cmd;
	logic [3:0] dec_chip;
	logic [1:0] dec_types;
	logic dec_all;
	modport saw_ctl(output saw_start, saw_count, input saw_busy, saw_tick);
	modport saw_gen(input saw_start, saw_count, output saw_busy, saw_tick);
	modport dec_user(output dec_payload,
		input dec_data, dec_chmask, dec_cmd, dec_chip, dec_types, dec_all);
	modport dec(input dec_payload,
		output dec_data, dec_chmask, dec_cmd, dec_chip, dec_types, dec_all);
endinterface
`default_nettype wire

// >>> src/dcc_dac_dec.sv
// Field decoder for threshold converter write payloads
`timescale 1ns/1ps
`default_nettype none
module dcc_dac_dec (
	dcc_link_if.dec lk
);
	import dcc_pkg::*;
	logic [3:0] ch;
	assign ch = lk.dec_payload[DAC_CH_LSB +: 4];
	assign lk.dec_data = lk.dec_payload[DAC_DATA_W-1:0];
	assign lk.dec_cmd = lk.dec_payload[DAC_CMD_LSB +: 4];
	assign lk.dec_chip = lk.dec_payload[DAC_CHIP_LSB +: 4];
	assign lk.dec_types = dcc_type_mask(lk.dec_payload[DAC_TYPE_LSB +: 2]);
	assign lk.dec_all = lk.dec_payload[BCAST_BIT];
	// One output per channel address 0-3, none for 4-14, all four on the group code
	assign lk.dec_chmask = (ch == DAC_ALL_CH) ? 4'hF :
		(ch[3:2] == 2'h0) ? (4'h1 << ch[1:0]) : 4'h0;
endmodule
`default_nettype wire

// >>> src/dcc_saw_gen.sv
// Sawtooth pulse sequencer: a counted train of one-cycle strobes
`timescale 1ns/1ps
`default_nettype none
module dcc_saw_gen #(
	parameter int PERIOD_CYC = dcc_pkg::SAW_PERIOD_CYC
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	dcc_link_if.saw_gen lk
);
	import dcc_pkg::*;
	localparam int TW = $clog2(PERIOD_CYC + 1);
	typedef struct packed {
		logic [7:0] left;
		logic [TW-1:0] timer;
		logic tick;
	} dcc_saw_s;
	dcc_saw_s s_ff;
	dcc_saw_s nxt_s;
	always_comb
	begin
		nxt_s = s_ff;
		nxt_s.tick = 1'b0;
		if (s_ff.timer != '0)
			nxt_s.timer = s_ff.timer - 1'b1;
		else if (s_ff.left != 8'h00)
		begin
			nxt_s.tick = 1'b1;
			nxt_s.left = s_ff.left - 8'h01;
			nxt_s.timer = TW'(PERIOD_CYC - 1);
		end
		if (lk.saw_start && s_ff.left == 8'h00 && s_ff.timer == '0)
			nxt_s.left = lk.saw_count;
	end
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			s_ff <= '0;
		else
			s_ff <= nxt_s;
	end
	// Start folds in so the caller sees busy in the launch cycle
	assign lk.saw_busy = lk.saw_start || s_ff.left != 8'h00 || s_ff.timer != '0;
	assign lk.saw_tick = s_ff.tick;
endmodule
`default_nettype wire

// >>> tb/dcc_host_model.sv
// Upstream controller model: issues commands and collects replies
`timescale 1ns/1ps
`default_nettype none
module dcc_host_model (
	input wire logic clk_in,
	input wire logic cmd_ready_in,
	output logic cmd_valid_out,
	output logic [15:0] command_identifier_out,
	output logic [31:0] cmd_payload_out,
	input wire logic rsp_valid_in,
	output logic rsp_ready_out,
	input wire logic [15:0] rsp_id_in,
	input wire logic [31:0] rsp_payload_in
);
	int slow = 0;
	initial
	begin
		cmd_valid_out = 1'b0;
		command_identifier_out = 16'h0000;
		cmd_payload_out = 32'h0000_0000;
		rsp_ready_out = 1'b0;
	end
	// One command at a time, held until taken, then the reply is awaited
	task automatic send(input logic [15:0] id, input logic [31:0] pay,
		output logic [15:0] r_id, output logic [31:0] r_pay, output logic ok);
		logic hit;
		int n;
		@(posedge clk_in);
		#1;
		cmd_valid_out = 1'b1;
		command_identifier_out = id;
		cmd_payload_out = pay;
		n = 0;
		do
		begin
			hit = cmd_ready_in;
			@(posedge clk_in);
			#1;
			n++;
		end
		while (!hit && n < 2000);
		ok = hit;
		cmd_valid_out = 1'b0;
		// Released lines do not keep the last value
		command_identifier_out = ~id;
		cmd_payload_out = ~pay;
		repeat (slow)
		begin
			@(posedge clk_in);
			#1;
		end
		rsp_ready_out = 1'b1;
		n = 0;
		do
		begin
			hit = rsp_valid_in;
			r_id = rsp_id_in;
			r_pay = rsp_payload_in;
			@(posedge clk_in);
			#1;
			n++;
		end
		while (!hit && n < 2000);
		ok = ok & hit;
		rsp_ready_out = 1'b0;
	endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking testbench of the sensor card command decoder
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import dcc_pkg::*;
	typedef struct {logic [15:0] id; logic [31:0] pay; logic [31:0] exp; int kind;
		logic [27:0] cap;} dcc_row_s;
	logic clk_in = 1'b0, rst_n_in = 1'b0, rdy = 1'b0;
	logic cmd_valid, cmd_ready, rsp_valid, rsp_ready, adc_valid, adc_def, adc_gain;
	logic [15:0] command_identifier, rsp_id, adc_data;
	logic [31:0] cmd_pay, rsp_pay;
	logic [1:0] adc_mask, dac_type, saw_type, thr_mode;
	logic [7:0] adc_addr, tdc_ctrl;
	logic dac_valid, dac_def, dac_all, saw_pulse, saw_busy, saw_all;
	logic tdc_rst, tdc_cal, tdc_run, thr_en;
	logic [9:0] dac_data;
	logic [3:0] dac_chan, dac_cmd, dac_chip, saw_chip;
	logic [11:0] thr_val;
	logic [27:0] cap;
	int miscompares = 0, n_compared = 0, n_pulse = 0;
	dcc_row_s rows [21];
	always #2.5 clk_in = ~clk_in;
	// Converter consumers stall every other cycle
	always @(posedge clk_in) rdy <= #1 ~rdy;
	always @(posedge clk_in) if (adc_valid && rdy) cap <= {adc_def, adc_mask, adc_addr, adc_data, adc_gain};
	always @(posedge clk_in) if (dac_valid && rdy)
		cap <= {2'h0, dac_def, dac_all, dac_type, dac_data, dac_chan, dac_cmd, dac_chip};
	always @(posedge clk_in) if (saw_pulse === 1'b1) n_pulse++;
	dcc_host_model host (.clk_in(clk_in), .cmd_ready_in(cmd_ready), .cmd_valid_out(cmd_valid),
		.command_identifier_out(command_identifier), .cmd_payload_out(cmd_pay), .rsp_valid_in(rsp_valid),
		.rsp_ready_out(rsp_ready), .rsp_id_in(rsp_id), .rsp_payload_in(rsp_pay));
	dcc_cmd_top #(.SAW_PERIOD(4)) uut (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.cmd_valid_in(cmd_valid), .cmd_ready_out(cmd_ready), .command_identifier_in(command_identifier),
		.cmd_payload_in(cmd_pay), .rsp_valid_out(rsp_valid), .rsp_ready_in(rsp_ready),
		.rsp_id_out(rsp_id), .rsp_payload_out(rsp_pay), .adc_valid_out(adc_valid),
		.adc_ready_in(rdy), .adc_default_out(adc_def), .adc_chip_mask_out(adc_mask),
		.adc_addr_out(adc_addr), .adc_data_out(adc_data), .adc_gain_out(adc_gain),
		.dac_valid_out(dac_valid), .dac_ready_in(rdy), .dac_default_out(dac_def),
		.dac_data_out(dac_data), .dac_chan_mask_out(dac_chan), .dac_cmd_out(dac_cmd),
		.dac_chip_out(dac_chip), .dac_all_chips_out(dac_all), .dac_type_mask_out(dac_type),
		.saw_pulse_out(saw_pulse), .saw_busy_out(saw_busy), .saw_chip_out(saw_chip),
		.saw_all_chips_out(saw_all), .saw_type_mask_out(saw_type), .tdc_ctrl_out(tdc_ctrl),
		.tdc_reset_out(tdc_rst), .tdc_cal_out(tdc_cal), .tdc_run_out(tdc_run),
		.thr_value_out(thr_val), .thr_mode_out(thr_mode), .thr_enable_out(thr_en));
	// ----------------------------------------
	// Checking and closing
	// ----------------------------------------
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic run(input dcc_row_s r);
		logic [15:0] g_id;
		logic [31:0] g_pay;
		logic ok;
		cap = 'x;
		host.send(r.id, r.pay, g_id, g_pay, ok);
		chk("reply_taken", {31'h0, ok}, 32'h1);
		chk("reply_id", {16'h0, g_id}, {16'h0, r.id | 16'h8000});
		chk("reply_payload", g_pay, r.exp);
		case (r.kind)
			1, 2: chk("converter_request", {4'h0, cap}, {4'h0, r.cap});
			3: chk("adc_reload", {29'h0, cap[27:25]}, {29'h0, r.cap[27:25]});
			4: chk("dac_reload", {28'h0, cap[25:22]}, {28'h0, r.cap[25:22]});
			5: chk("tdc_flags", {29'h0, tdc_rst, tdc_cal, tdc_run}, {29'h0, r.cap[2:0]});
			6: chk("threshold", {17'h0, thr_en, thr_mode, thr_val}, {17'h0, r.cap[14:0]});
			default: ;
		endcase
	endtask
	task automatic chk_rst();
		chk("reset_state", {4'h0, cmd_ready, rsp_valid, adc_valid, dac_valid, saw_busy, saw_pulse,
			thr_mode, thr_val, tdc_ctrl}, {4'h0, 1'b1, 5'h0, 2'h0, 12'h800, 8'h00});
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		while (saw_busy !== 1'b0 && n < 5000)
		begin
			@(posedge clk_in);
			#1;
			n++;
		end
	endtask
	initial
	begin
		#200000;
		miscompares++;
		give_verdict();
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		rows = '{'{16'h0101, 32'hFFFFFF04, 0, 0, 0}, '{16'h0102, 32'hDEADFEED, 32'h04, 5, 28'h1},
			'{16'h0101, 32'h02, 0, 0, 0}, '{16'h0102, 32'hDEADFEED, 32'h02, 5, 28'h2},
			'{16'h0101, 32'h80, 0, 0, 0}, '{16'h0102, 32'h0, 32'h80, 5, 28'h4},
			'{16'h0108, 32'h00010800, 0, 6, {13'h0, 1'b1, 2'h1, 12'h800}},
			'{16'h0109, 32'hDEADFEED, 32'h00010800, 0, 0},
			'{16'h0108, 32'hFFFCF123, 0, 6, {13'h0, 1'b0, 2'h0, 12'h123}},
			'{16'h0109, 32'h0, 32'h123, 0, 0},
			'{16'h0104, 32'h00AC6666, 0, 1, {1'b0, 2'h1, 8'h2B, 16'h6666, 1'b1}},
			'{16'h0104, 32'h88A88888, 0, 1, {1'b0, 2'h3, 8'h2A, 16'h8888, 1'b1}},
			'{16'h0104, 32'h08A81234, 0, 1, {1'b0, 2'h2, 8'h2A, 16'h1234, 1'b1}},
			'{16'h0104, 32'h00141111, 0, 1, {1'b0, 2'h1, 8'h05, 16'h1111, 1'b0}},
			'{16'h0103, 32'hDEADFEED, 0, 3, {1'b1, 2'h3, 25'h0}},
			'{16'h0106, 32'h00860120, 0, 2, {4'h0, 2'h1, 10'h120, 4'h1, 4'h3, 4'h1}},
			'{16'h0106, 32'h898600CD, 0, 2, {4'h1, 2'h2, 10'h0CD, 4'h1, 4'h3, 4'h3}},
			'{16'h0106, 32'h1107FFFF, 0, 2, {4'h0, 2'h0, 10'h3FF, 4'hF, 4'h3, 4'h2}},
			'{16'h0106, 32'h18064005, 0, 2, {4'h0, 2'h3, 10'h005, 4'h4, 4'h3, 4'h0}},
			'{16'h0105, 32'hDEADFEED, 0, 4, {2'h0, 1'b1, 1'b1, 2'h3, 22'h0}},
			'{16'h0055, 32'h12345678, 0, 0, 0}};
		repeat (16) @(posedge clk_in);
		chk_rst();
		#1;
		rst_n_in = 1'b1;
		$display("reset test done");
		foreach (rows[i])
			run(rows[i]);
		$display("table test done");
		run('{16'h8107, 32'h800000C2, 0, 0, 0});
		wait_idle();
		chk("saw_pulses", n_pulse, 32'd3);
		chk("saw_target", {25'h0, saw_chip, saw_all, saw_type}, {25'h0, 4'h2, 1'b1, 2'h1});
		host.slow = 3;
		run('{16'h0107, 32'h0000007F, 0, 0, 0});
		chk("saw_blocking", {30'h0, saw_busy, 1'b0}, 32'h0);
		chk("saw_pulses", n_pulse, 32'd4);
		chk("saw_target", {25'h0, saw_chip, saw_all, saw_type}, {25'h0, 4'hF, 1'b0, 2'h3});
		run('{16'h0107, 32'h00000010, 0, 0, 0});
		chk("saw_zero", n_pulse, 32'd4);
		host.slow = 0;
		$display("sawtooth test done");
		run('{16'h8107, 32'h00003FC0, 0, 0, 0});
		repeat (5) @(posedge clk_in);
		#1;
		rst_n_in = 1'b0;
		repeat (3) @(posedge clk_in);
		chk_rst();
		#1;
		rst_n_in = 1'b1;
		run('{16'h0109, 32'hFFFFFFFF, 32'h800, 0, 0});
		run('{16'h0102, 32'hFFFFFFFF, 32'h0, 0, 0});
		$display("mid-run reset test done");
		give_verdict();
	end
endmodule
`default_nettype wire
